/* design/capture_pkg.sv */
// shared constants, modes and carriers of the edge capture unit
package capture_pkg;

   // ==================================================
   // register byte offsets
   localparam logic [7:0] ADR_TB_CTRL  = 8'h00;
   localparam logic [7:0] ADR_TB_COUNT = 8'h04;
   localparam logic [7:0] ADR_FLAGS    = 8'h08;
   localparam logic [7:0] ADR_MASK     = 8'h0C;
   localparam logic [7:0] ADR_ALT_PIN  = 8'h10;
   localparam logic [7:0] ADR_CH_BASE  = 8'h20;
   localparam logic [3:0] CH_CTRL      = 4'h0;
   localparam logic [3:0] CH_VAL_LOW   = 4'h4;
   localparam logic [3:0] CH_VAL_HIGH  = 4'h8;
   localparam logic [3:0] CH_PORT      = 4'hC;

   // ==================================================
   // field positions
   localparam int TB_ON_BIT    = 0;
   localparam int TB_EXT_BIT   = 1;
   localparam int PORT_OUT_BIT = 0;
   localparam int PORT_DIR_BIT = 1;
   localparam int CH_SHIFT     = 4;

   // ==================================================
   // reset values
   localparam logic [1:0] TB_CTRL_RST = 2'h0;
   localparam logic [1:0] PORT_RST    = 2'h2;
   localparam logic [3:0] MODE_RST    = 4'h0;

   // ==================================================
   // timing: instruction clock is the system clock divided by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [3:0] PRE4_LAST      = 4'h3;
   localparam logic [3:0] PRE16_LAST     = 4'hF;

   // ==================================================
   // modes and carriers
   typedef enum logic [3:0] {
      MODE_OFF    = 4'b0000,
      MODE_FALL   = 4'b0100,
      MODE_RISE   = 4'b0101,
      MODE_RISE4  = 4'b0110,
      MODE_RISE16 = 4'b0111
   } capture_mode_e;

   typedef struct packed {
      logic [3:0] mode;
      logic       portOut;
      logic       dirIn;
   } chan_ctrl_s;

endpackage : capture_pkg

/* design/shared_timebase.sv */
// shared 16-bit timebase with instruction or external count source
`timescale 1ns/1ns
module shared_timebase
   import capture_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             on,
   input  wire logic             extSrc,
   input  wire logic             sleep,
   input  wire logic             extClkIn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic      [WIDTH-1:0] count
);
   logic [1:0] div;
   logic       ext1;
   logic       ext2;
   logic       ext3;
   wire        instrTick = (div == INSTR_DIV_LAST);
   wire        extRise   = ext2 & ~ext3;
   // internal source halts in sleep, external keeps running
   wire        step = on &
                      (extSrc ? extRise : (instrTick & ~sleep));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div   <= 2'h0;
         ext1  <= 1'b0;
         ext2  <= 1'b0;
         ext3  <= 1'b0;
         count <= '0;
      end else if (ce) begin
         div  <= div + 2'h1;
         ext1 <= extClkIn;
         ext2 <= ext1;
         ext3 <= ext2;
         if (load) begin
            count <= loadValue;
         end else if (step) begin
            count <= count + WIDTH'(1);
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sleepHold_a: assert property (
      (ce && sleep && !extSrc && !load) |=> $stable(count))
      else $error("timebase advanced in sleep on internal source");
   extRun_a: assert property (
      (ce && on && extSrc && extRise && !load)
         |=> count == $past(count) + WIDTH'(1))
      else $error("external source edge did not advance timebase");
endmodule : shared_timebase

/* design/capture_channel.sv */
// one capture channel: synchroniser, edge select, prescaler, value
`timescale 1ns/1ns
module capture_channel
   import capture_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [3:0]       mode,
   input  wire logic             pinLevel,
   input  wire logic [WIDTH-1:0] count,
   output logic                  eventHit,
   output logic      [WIDTH-1:0] captureValue
);
   logic       sync1;
   logic       sync2;
   logic       last;
   logic [3:0] preCount;

   wire rise      = sync2 & ~last;
   wire fall      = ~sync2 & last;
   wire inCapture = (mode == MODE_FALL) | (mode == MODE_RISE) |
                    (mode == MODE_RISE4) | (mode == MODE_RISE16);
   wire preLast   = (mode == MODE_RISE4) ? (preCount == PRE4_LAST)
                                         : (preCount == PRE16_LAST);
   // prescaler is not cleared between prescaled modes: a direct switch
   // may fire early, software must pass through off first
   wire preMode   = (mode == MODE_RISE4) | (mode == MODE_RISE16);

   always_comb begin
      eventHit = 1'b0;
      if (mode == MODE_FALL) begin
         eventHit = fall;
      end else if (mode == MODE_RISE) begin
         eventHit = rise;
      end else if (preMode) begin
         eventHit = rise & preLast;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1        <= 1'b0;
         sync2        <= 1'b0;
         last         <= 1'b0;
         preCount     <= 4'h0;
         captureValue <= '0;
      end else if (ce) begin
         sync1 <= pinLevel;
         sync2 <= sync1;
         last  <= sync2;
         if (!inCapture) begin
            preCount <= 4'h0;
         end else if (preMode && rise) begin
            preCount <= preLast ? 4'h0 : preCount + 4'h1;
         end
         if (eventHit) begin
            captureValue <= count;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   captureCopy_a: assert property (
      (ce && eventHit) |=> captureValue == $past(count))
      else $error("capture value differs from timebase");
   prescaleClear_a: assert property (
      (ce && !inCapture) |=> preCount == 4'h0)
      else $error("prescaler not cleared outside capture");
   sixteenth_a: assert property (
      (eventHit && mode == MODE_RISE16) |-> preCount == PRE16_LAST && rise)
      else $error("sixteenth edge capture at wrong count");
   // watches the synchroniser pipeline, not the edge wire itself
   fallEdge_a: assert property (
      (ce && mode == MODE_FALL && sync2 && !sync1)
         |=> (eventHit || !ce || mode != MODE_FALL))
      else $error("falling edge missed");
   singleHit_a: assert property (
      (ce && eventHit) |=> !eventHit)
      else $error("one edge produced two captures");
endmodule : capture_channel

/* design/timer_edge_capture_unit.sv */
// top of the edge capture unit: bus slave, flags, pins, channels
//
// Behaviour
// - a qualifying event copies the 16-bit timebase, high and low bytes
// - mode field picks falling, rising, every 4th or 16th rising edge
// - every capture sets that channel's event flag
// - the event flag stays set until software clears it
// - a new capture overwrites an unread value, no overrun guard
// - with the pin as output, a port write can trigger a capture
// - capture input may be routed to an alternative pin
// - mode change may raise a false flag; software clears it after
// - prescaler cleared whenever the channel is off or not capturing
// - every reset clears the prescaler
// - switching prescale directly may misfire; write zero first
// - on instruction clock, timebase holds during sleep and resumes
// - on external source, capture keeps working in sleep
// - all five channels behave identically
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
module timer_edge_capture_unit
   import capture_pkg::*;
#(
   parameter int CHANNELS = 5,
   parameter int WIDTH    = 16
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic                sleep,
   input  wire logic                extClkIn,
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [7:0]          adr_i,
   input  wire logic [31:0]         dat_i,
   input  wire logic [3:0]          sel_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   input  wire logic [CHANNELS-1:0] pinIn,
   output logic      [CHANNELS-1:0] pinOut,
   output logic      [CHANNELS-1:0] pinOe,
   input  wire logic [CHANNELS-1:0] altPinIn,
   output logic      [CHANNELS-1:0] altPinOut,
   output logic      [CHANNELS-1:0] altPinOe,
   output logic                     irq
);
   // ==================================================
   // state
   logic [1:0]          tbCtrl;
   logic [CHANNELS-1:0] flags;
   logic [CHANNELS-1:0] mask;
   logic [CHANNELS-1:0] altSel;
   chan_ctrl_s          chCtrl [CHANNELS];
   logic [WIDTH-1:0]    count;
   logic [WIDTH-1:0]    chValue [CHANNELS];
   logic [CHANNELS-1:0] capHit;
   logic [CHANNELS-1:0] pinLevel;

   // ==================================================
   // bus decode
   wire        request  = cyc_i & stb_i & ~ack_o;
   wire        wrLow    = request & we_i & sel_i[0];
   wire        wrHigh   = request & we_i & sel_i[1];
   wire [7:0]  chOffset = adr_i - ADR_CH_BASE;
   wire [3:0]  chIdx    = chOffset[7:CH_SHIFT];
   wire [3:0]  chSub    = adr_i[3:0];
   wire        chHit    = (adr_i >= ADR_CH_BASE) &&
                          (chIdx < 4'(CHANNELS));
   wire        hitCtrl  = (adr_i == ADR_TB_CTRL);
   wire        hitCount = (adr_i == ADR_TB_COUNT);
   wire        hitFlags = (adr_i == ADR_FLAGS);
   wire        hitMask  = (adr_i == ADR_MASK);
   wire        hitAlt   = (adr_i == ADR_ALT_PIN);
   wire [CHANNELS-1:0] flagClear =
      (wrLow && hitFlags) ? dat_i[CHANNELS-1:0] : '0;
   wire        tbLoad   = (wrLow | wrHigh) & hitCount;
   wire [WIDTH-1:0] tbLoadValue = {
      wrHigh ? dat_i[15:8] : count[15:8],
      wrLow  ? dat_i[7:0]  : count[7:0]};

   // ==================================================
   // read selection; unmapped addresses answer zero
   chan_ctrl_s      selCtrl;
   logic [WIDTH-1:0] selValue;
   logic [31:0]     chWord;
   logic [31:0]     readWord;

   assign selCtrl  = chHit ? chCtrl[chIdx[2:0]] : '0;
   assign selValue = chHit ? chValue[chIdx[2:0]] : '0;
   assign chWord   =
      (chSub == CH_CTRL)     ? {28'h0, selCtrl.mode} :
      (chSub == CH_VAL_LOW)  ? {24'h0, selValue[7:0]} :
      (chSub == CH_VAL_HIGH) ? {24'h0, selValue[15:8]} :
      (chSub == CH_PORT)     ? {30'h0, selCtrl.dirIn, selCtrl.portOut} :
                               32'h0;
   assign readWord =
      hitCtrl  ? {30'h0, tbCtrl} :
      hitCount ? {16'h0, count} :
      hitFlags ? 32'(flags) :
      hitMask  ? 32'(mask) :
      hitAlt   ? 32'(altSel) :
      chHit    ? chWord : 32'h0;

   // ==================================================
   // bus slave: one wait state, ack for a single cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else if (ce) begin
         ack_o <= request;
         if (request) begin
            dat_o <= readWord;
         end
      end
   end

   // ==================================================
   // global registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tbCtrl <= TB_CTRL_RST;
         mask   <= '0;
         altSel <= '0;
      end else if (ce && wrLow) begin
         if (hitCtrl) begin
            tbCtrl <= dat_i[1:0];
         end else if (hitMask) begin
            mask <= dat_i[CHANNELS-1:0];
         end else if (hitAlt) begin
            altSel <= dat_i[CHANNELS-1:0];
         end
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= '0;
      end else if (ce) begin
         flags <= (flags & ~flagClear) | capHit;
      end
   end

   assign irq = |(flags & mask);

   // ==================================================
   // shared timebase
   shared_timebase #(
      .WIDTH (WIDTH)
   ) u_timebase (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .on        (tbCtrl[TB_ON_BIT]),
      .extSrc    (tbCtrl[TB_EXT_BIT]),
      .sleep     (sleep),
      .extClkIn  (extClkIn),
      .load      (tbLoad),
      .loadValue (tbLoadValue),
      .count     (count)
   );

   // ==================================================
   // channels
   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      wire wrThis = ce && wrLow && chHit && (chIdx == 4'(i));

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            chCtrl[i].mode    <= MODE_RST;
            chCtrl[i].portOut <= PORT_RST[PORT_OUT_BIT];
            chCtrl[i].dirIn   <= PORT_RST[PORT_DIR_BIT];
         end else if (wrThis && chSub == CH_CTRL) begin
            // a mode change may leave a stale edge that flags once
            chCtrl[i].mode <= dat_i[3:0];
         end else if (wrThis && chSub == CH_PORT) begin
            chCtrl[i].portOut <= dat_i[PORT_OUT_BIT];
            chCtrl[i].dirIn   <= dat_i[PORT_DIR_BIT];
         end
      end

      // an output-configured pin feeds back its own latch
      assign pinLevel[i] = !chCtrl[i].dirIn ? chCtrl[i].portOut :
                           altSel[i] ? altPinIn[i] : pinIn[i];
      assign pinOut[i]    = chCtrl[i].portOut;
      assign altPinOut[i] = chCtrl[i].portOut;
      assign pinOe[i]     = !chCtrl[i].dirIn && !altSel[i];
      assign altPinOe[i]  = !chCtrl[i].dirIn && altSel[i];

      capture_channel #(
         .WIDTH (WIDTH)
      ) u_channel (
         .clk          (clk),
         .rst          (rst),
         .ce           (ce),
         .mode         (chCtrl[i].mode),
         .pinLevel     (pinLevel[i]),
         .count        (count),
         .eventHit     (capHit[i]),
         .captureValue (chValue[i])
      );
   end

   // ==================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence busReq;
      ce && request;
   endsequence

   ackPulse_a: assert property (
      busReq |=> ack_o ##1 (!ack_o || !ce))
      else $error("bus ack not a single cycle after request");
   flagSet_a: assert property (
      (ce && |capHit) |=> (flags & $past(capHit)) == $past(capHit))
      else $error("capture did not set its flag");
   flagSticky_a: assert property (
      (ce && flagClear == '0) |=> (flags & $past(flags)) == $past(flags))
      else $error("flag cleared without software");
   irqLevel_a: assert property (
      (ce && |(capHit & mask)) |=> irq)
      else $error("unmasked capture did not raise interrupt");
   outDrive_a: assert property (
      (ce && wrLow && chHit && chSub == CH_PORT && !dat_i[PORT_DIR_BIT])
         |=> |(pinOe | altPinOe))
      else $error("output configured pin not driven");
endmodule : timer_edge_capture_unit

/* sim/signal_source.sv */
// external signal source driving the capture pins and timebase clock
`timescale 1ns/1ns
module signal_source #(
   parameter int CHANNELS = 5
) (
   input  wire logic                clk,
   output logic      [CHANNELS-1:0] pinIn,
   output logic      [CHANNELS-1:0] altPinIn,
   output logic                     extClkIn
);
   // ==================================================
   // pin levels
   initial begin
      pinIn    = '0;
      altPinIn = '0;
      extClkIn = 1'b0;
   end

   // level held three cycles: the two synchroniser stages and the edge detect take that long to capture it
   task automatic drive(input int ch, input logic alt, input logic lvl);
      @(posedge clk);
      if (alt) begin
         altPinIn[ch] <= lvl;
      end else begin
         pinIn[ch] <= lvl;
      end
      repeat (3) @(posedge clk);
   endtask : drive

   // ==================================================
   // external timebase source, slow enough for a synchronised count
   task automatic extTicks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         extClkIn <= 1'b1;
         repeat (2) @(posedge clk);
         extClkIn <= 1'b0;
         @(posedge clk);
      end
   endtask : extTicks
endmodule : signal_source

/* sim/test_timer_edge_capture_unit.sv */
// self-checking bench of the edge capture unit
`timescale 1ns/1ns
module test_timer_edge_capture_unit;
   import capture_pkg::*;
   // ==================================================
   // signals
   localparam logic [3:0] MODES [4] = '{MODE_FALL, MODE_RISE,
                                        MODE_RISE4, MODE_RISE16};
   localparam int         NEED  [4] = '{1, 1, 4, 16};
   logic        clk, rst, sleep, cyc, stb, we, ack, irq, extClkIn, expFlag;
   logic        ce;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] datW, datR, d, b;
   logic [4:0]  pinIn, altPinIn, pinOut, pinOe, altPinOut, altPinOe;
   int          err_total, n_tests;

   timer_edge_capture_unit u_timer_edge_capture_unit (
      .clk(clk), .rst(rst), .ce(ce), .sleep(sleep),
      .extClkIn(extClkIn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(datW), .sel_i(sel), .dat_o(datR),
      .ack_o(ack), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .altPinIn(altPinIn), .altPinOut(altPinOut), .altPinOe(altPinOe),
      .irq(irq));
   signal_source u_signal_source (
      .clk(clk), .pinIn(pinIn), .altPinIn(altPinIn),
      .extClkIn(extClkIn));

   // ==================================================
   // helpers
   function automatic logic [7:0] chAdr(input int n, input logic [3:0] o);
      return ADR_CH_BASE + 8'(n << CH_SHIFT) + {4'h0, o};
   endfunction : chAdr

   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   // answer time is the slave's own; the bound only stops a hang
   task automatic wbXfer(input logic w, input logic [7:0] a,
                         input logic [31:0] wd, output logic [31:0] rd);
      int t;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      datW <= wd;
      sel  <= 4'hF;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 20);
      rd = datR;
      check("ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wbXfer

   task automatic wbWrite(input logic [7:0] a, input logic [31:0] wd);
      wbXfer(1'b1, a, wd, b);
   endtask : wbWrite

   task automatic wbRead(input logic [7:0] a, output logic [31:0] rd);
      wbXfer(1'b0, a, 32'h0, rd);
   endtask : wbRead

   task automatic flagIs(input int ch, input logic e);
      wbRead(ADR_FLAGS, d);
      check("flag", {31'h0, e}, {31'h0, d[ch]});
   endtask : flagIs

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   // ==================================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end

   // ==================================================
   // tests
   initial begin
      {rst, sleep, cyc, stb, we, adr, datW, sel} = '0;
      rst = 1'b1;
      ce = 1'b1;
      err_total = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wbRead(ADR_FLAGS, d);
      check("flags at reset", 32'h0, d);
      wbRead(chAdr(0, CH_PORT), d);
      check("port at reset", {30'h0, PORT_RST}, d);
      wbRead(8'hFC, d);
      check("unmapped read", 32'h0, d);
      check("irq at reset", 32'h0, {31'h0, irq});
      wbWrite(ADR_MASK, 32'h1F);
      // one mode per channel, so channels 0 to 3 are exercised
      for (int m = 0; m < 4; m++) begin
         wbWrite(ADR_TB_COUNT, 32'(16'hA5C3 + 16'(m)));
         wbWrite(chAdr(m, CH_CTRL), {28'h0, MODES[m]});
         wbWrite(ADR_FLAGS, 32'h1F);
         expFlag = 1'b0;
         for (int e = 1; e <= NEED[m]; e++) begin
            u_signal_source.drive(m, 1'b0, 1'b1);
            if (m == 1 || (m > 1 && e == NEED[m])) expFlag = 1'b1;
            flagIs(m, expFlag);
            u_signal_source.drive(m, 1'b0, 1'b0);
            if (m == 0) expFlag = 1'b1;
            flagIs(m, expFlag);
         end
         wbRead(chAdr(m, CH_VAL_LOW), d);
         check("value low", 32'(8'hC3 + 8'(m)), d);
         wbRead(chAdr(m, CH_VAL_HIGH), d);
         check("value high", 32'hA5, d);
         check("irq raised", 32'h1, {31'h0, irq});
      end
      // overwrite without read, sticky flag, mask
      wbWrite(ADR_TB_COUNT, 32'h1357);
      u_signal_source.drive(1, 1'b0, 1'b1);
      u_signal_source.drive(1, 1'b0, 1'b0);
      wbWrite(ADR_TB_COUNT, 32'h2468);
      u_signal_source.drive(1, 1'b0, 1'b1);
      wbRead(chAdr(1, CH_VAL_LOW), d);
      check("overwrite low", 32'h68, d);
      repeat (30) @(posedge clk);
      flagIs(1, 1'b1);
      wbWrite(ADR_MASK, 32'h0);
      check("irq masked", 32'h0, {31'h0, irq});
      wbWrite(ADR_FLAGS, 32'h02);
      flagIs(1, 1'b0);
      wbWrite(ADR_MASK, 32'h1F);
      // prescaler cleared on leaving capture mode
      for (int e = 0; e < 2; e++) begin
         u_signal_source.drive(2, 1'b0, 1'b1);
         u_signal_source.drive(2, 1'b0, 1'b0);
      end
      wbWrite(chAdr(2, CH_CTRL), {28'h0, MODE_OFF});
      wbWrite(chAdr(2, CH_CTRL), {28'h0, MODE_RISE4});
      wbWrite(ADR_FLAGS, 32'h1F);
      for (int e = 1; e <= 4; e++) begin
         u_signal_source.drive(2, 1'b0, 1'b1);
         flagIs(2, e == 4);
         u_signal_source.drive(2, 1'b0, 1'b0);
      end
      // port write on an output pin triggers a capture
      wbWrite(chAdr(3, CH_CTRL), {28'h0, MODE_RISE});
      wbWrite(chAdr(3, CH_PORT), 32'h0);
      wbWrite(ADR_FLAGS, 32'h1F);
      check("pin driven", 32'h1, {31'h0, pinOe[3]});
      wbWrite(ADR_TB_COUNT, 32'h0F0F);
      wbWrite(chAdr(3, CH_PORT), 32'h1);
      repeat (4) @(posedge clk);
      flagIs(3, 1'b1);
      check("pin level", 32'h1, {31'h0, pinOut[3]});
      // alternative pin routing
      wbWrite(ADR_ALT_PIN, 32'h10);
      wbWrite(chAdr(4, CH_CTRL), {28'h0, MODE_RISE});
      wbWrite(ADR_FLAGS, 32'h1F);
      u_signal_source.drive(4, 1'b0, 1'b1);
      flagIs(4, 1'b0);
      u_signal_source.drive(4, 1'b1, 1'b1);
      flagIs(4, 1'b1);
      wbWrite(chAdr(4, CH_PORT), 32'h1);
      check("alt driven", 32'h10, {27'h0, altPinOe & ~pinOe});
      check("alt level", 32'h1, {31'h0, altPinOut[4]});
      // sleep on instruction clock holds the count
      wbWrite(ADR_TB_CTRL, 32'h1);
      sleep <= 1'b1;
      wbRead(ADR_TB_COUNT, d);
      repeat (20) @(posedge clk);
      wbRead(ADR_TB_COUNT, b);
      check("held in sleep", d, b);
      sleep <= 1'b0;
      repeat (40) @(posedge clk);
      wbRead(ADR_TB_COUNT, d);
      check("resumed", 32'h1, {31'h0, (d - b) inside {[9:12]}});
      // external source keeps counting and capturing in sleep
      wbWrite(ADR_TB_CTRL, 32'h3);
      wbWrite(ADR_TB_COUNT, 32'h0);
      sleep <= 1'b1;
      u_signal_source.extTicks(10);
      repeat (4) @(posedge clk);
      wbRead(ADR_TB_COUNT, d);
      check("external count", 32'hA, d);
      wbWrite(ADR_FLAGS, 32'h1F);
      u_signal_source.drive(0, 1'b0, 1'b1);
      u_signal_source.drive(0, 1'b0, 1'b0);
      flagIs(0, 1'b1);
      wbRead(chAdr(0, CH_VAL_LOW), d);
      check("sleep capture", 32'hA, d);
      // clock enable low freezes the synchroniser, so the pulse is lost
      wbWrite(ADR_FLAGS, 32'h1F);
      ce <= 1'b0;
      u_signal_source.drive(1, 1'b0, 1'b1);
      u_signal_source.drive(1, 1'b0, 1'b0);
      ce <= 1'b1;
      flagIs(1, 1'b0);
      // reset in mid-run with the prescaler part way through
      u_signal_source.drive(2, 1'b0, 1'b1);
      u_signal_source.drive(2, 1'b0, 1'b0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check("irq after reset", 32'h0, {31'h0, irq});
      check("oe after reset", 32'h0, {22'h0, pinOe, altPinOe});
      wbRead(ADR_TB_COUNT, d);
      check("count after reset", 32'h0, d);
      wbWrite(chAdr(2, CH_CTRL), {28'h0, MODE_RISE4});
      for (int e = 1; e <= 4; e++) begin
         u_signal_source.drive(2, 1'b0, 1'b1);
         u_signal_source.drive(2, 1'b0, 1'b0);
         flagIs(2, e == 4);
      end
      conclude();
   end
endmodule : test_timer_edge_capture_unit
